// file: core/rtc_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module rtc_ctrl
    import rtc_ctrl_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h50
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic osc_clk,
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic backup_supply,
    output logic irq,
    output logic charger_path_closed,
    output logic charger_diode_bypass,
    output logic charger_active
);
    // ************************************************************
    // Input synchronisers and crossings
    // ************************************************************
    logic [2:0] pin_s;
    logic [1:0] osc_s;
    logic scl_s, sda_s, backup_s, wave_s, sec_tog_s;
    logic scl_d_q, sda_d_q, sec_tog_d_q;
    logic start_cond, stop_cond, scl_rise, scl_fall, sec_tick;
    logic wave_osc, sec_tog_osc;

    rtc_sync #(.W(3)) u_pin_sync (
        .clk(clk),
        .d({scl, sda_in, backup_supply}),
        .q(pin_s)
    );
    rtc_sync #(.W(2)) u_osc_sync (
        .clk(clk),
        .d({wave_osc, sec_tog_osc}),
        .q(osc_s)
    );
    assign {scl_s, sda_s, backup_s} = pin_s;
    assign {wave_s, sec_tog_s} = osc_s;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            scl_d_q <= 1'b1;
            sda_d_q <= 1'b1;
            sec_tog_d_q <= 1'b0;
        end else begin
            scl_d_q <= scl_s;
            sda_d_q <= sda_s;
            sec_tog_d_q <= sec_tog_s;
        end
    end

    assign start_cond = scl_s & scl_d_q & sda_d_q & ~sda_s;
    assign stop_cond = scl_s & scl_d_q & ~sda_d_q & sda_s;
    assign scl_rise = scl_s & ~scl_d_q;
    assign scl_fall = ~scl_s & scl_d_q;
    assign sec_tick = sec_tog_s ^ sec_tog_d_q;

    // ************************************************************
    // Register storage
    // ************************************************************
    logic [7:0] sec_q, min_q, hour_q, day_q, date_q, month_q, year_q;
    logic [7:0] trim_q, chg_sw_q, chg_cfg_q, prot_q;
    unlock_t unlock_q;
    logic wr_stb_q;
    logic [7:0] wr_ptr_q, wr_data_q;
    logic [7:0] rd_data;
    logic [7:0] ptr_q;

    rtc_timebase u_timebase (
        .osc_clk(osc_clk),
        .nrst(nrst),
        .trim_cfg({prot_q[PROT_RATE_BIT], trim_q[5:0]}),
        .wave_q(wave_osc),
        .sec_toggle_q(sec_tog_osc)
    );

    always_comb begin
        unique case (ptr_q)
            OFS_SECONDS: rd_data = sec_q;
            OFS_MINUTES: rd_data = min_q;
            OFS_HOURS: rd_data = hour_q;
            OFS_DAY: rd_data = day_q;
            OFS_DATE: rd_data = date_q;
            OFS_MONTH: rd_data = month_q;
            OFS_YEARS: rd_data = year_q;
            OFS_TRIM: rd_data = trim_q;
            OFS_CHG_SW: rd_data = chg_sw_q;
            OFS_CHG_CFG: rd_data = chg_cfg_q;
            OFS_KEY_ONE: rd_data = KEY_READ_VAL;
            OFS_KEY_TWO: rd_data = KEY_READ_VAL;
            OFS_PROT: rd_data = prot_q;
            default: rd_data = RST_ZERO;
        endcase
    end

    // ************************************************************
    // Time counters
    // ************************************************************
    // A host write in the same cycle as a tick wins for its own field
    always_ff @(posedge clk) begin
        if (!nrst) begin
            sec_q <= RST_ZERO;
            min_q <= RST_ZERO;
            hour_q <= RST_ZERO;
            day_q <= RST_ONE;
            date_q <= RST_ONE;
            month_q <= RST_ONE;
            year_q <= RST_ZERO;
        end else begin
            if (sec_tick) begin
                sec_q <= bcd_inc(sec_q, RST_ZERO, MAX_SEC);
                if (sec_q == MAX_SEC) begin
                    min_q <= bcd_inc(min_q, RST_ZERO, MAX_SEC);
                    if (min_q == MAX_SEC) begin
                        hour_q[5:0] <= 6'(bcd_inc({2'b00, hour_q[5:0]}, RST_ZERO, MAX_HOUR));
                        if (hour_q[5:0] == MAX_HOUR[5:0]) begin
                            day_q <= bcd_inc(day_q, RST_ONE, MAX_DAY);
                            date_q <= bcd_inc(date_q, RST_ONE, month_last(month_q, year_q));
                            if (date_q == month_last(month_q, year_q)) begin
                                month_q <= bcd_inc(month_q, RST_ONE, MAX_MONTH);
                                if (month_q == MAX_MONTH) begin
                                    year_q <= bcd_inc(year_q, RST_ZERO, MAX_YEAR);
                                    if (year_q == MAX_YEAR && hour_q[CENT_EN_BIT]) begin
                                        hour_q[CENT_BIT] <= ~hour_q[CENT_BIT];
                                    end
                                end
                            end
                        end
                    end
                end
            end
            if (wr_stb_q) begin
                unique case (wr_ptr_q)
                    OFS_SECONDS: sec_q <= wr_data_q & SEC_MASK;
                    OFS_MINUTES: min_q <= wr_data_q & SEC_MASK;
                    OFS_HOURS: hour_q <= wr_data_q;
                    OFS_DAY: day_q <= wr_data_q & DAY_MASK;
                    OFS_DATE: date_q <= wr_data_q & DATE_MASK;
                    OFS_MONTH: month_q <= wr_data_q & MONTH_MASK;
                    OFS_YEARS: year_q <= wr_data_q;
                    default: ;
                endcase
            end
        end
    end

    // ************************************************************
    // Control registers and unlock sequence
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!nrst) begin
            trim_q <= RST_TRIM;
            chg_sw_q <= RST_CHG_SW;
            chg_cfg_q <= RST_CHG_CFG;
            prot_q <= RST_PROT;
            unlock_q <= LOCKED;
        end else if (wr_stb_q) begin
            unlock_q <= LOCKED;
            unique case (wr_ptr_q)
                OFS_TRIM: trim_q <= wr_data_q;
                OFS_CHG_SW: chg_sw_q <= wr_data_q;
                OFS_CHG_CFG: chg_cfg_q <= wr_data_q;
                OFS_KEY_ONE: begin
                    if (wr_data_q == KEY_ONE_VAL) begin
                        unlock_q <= KEY_ONE_SEEN;
                    end
                end
                OFS_KEY_TWO: begin
                    if (unlock_q == KEY_ONE_SEEN && wr_data_q == KEY_TWO_VAL) begin
                        unlock_q <= UNLOCKED;
                    end
                end
                OFS_PROT: begin
                    if (unlock_q == UNLOCKED) begin
                        prot_q <= wr_data_q;
                    end
                end
                default: ;
            endcase
        end
    end

    // ************************************************************
    // Pin outputs
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!nrst) begin
            irq <= 1'b1;
            charger_path_closed <= 1'b0;
            charger_diode_bypass <= 1'b0;
            charger_active <= 1'b0;
        end else begin
            irq <= trim_q[TRIM_TEST_BIT] ? wave_s : trim_q[TRIM_OUT_BIT];
            charger_path_closed <= chg_sw_q[CHG_PATH_BIT];
            charger_diode_bypass <= chg_cfg_q[CHG_BYPASS_BIT];
            // Charging needs the path switch closed and enable code 5 in the low nibble of the charger config
            charger_active <= chg_sw_q[CHG_PATH_BIT] && (chg_cfg_q[3:0] == CHG_CODE_ON);
        end
    end

    // ************************************************************
    // Two-wire bus slave
    // ************************************************************
    bus_state_t state_q;
    logic [3:0] cnt_q;
    logic [7:0] sh_q;
    logic nack_q;

    // Open-drain line is only ever pulled low
    always_ff @(posedge clk) begin
        sda_out <= 1'b0;
    end

    always_ff @(posedge clk) begin
        wr_stb_q <= 1'b0;
        if (!nrst || backup_s) begin
            state_q <= ST_IDLE;
            cnt_q <= 4'd0;
            sh_q <= RST_ZERO;
            ptr_q <= RST_ZERO;
            nack_q <= 1'b0;
            sda_oe_n <= 1'b1;
            wr_ptr_q <= RST_ZERO;
            wr_data_q <= RST_ZERO;
        end else if (start_cond) begin
            state_q <= ST_ADDR;
            cnt_q <= 4'd0;
            sda_oe_n <= 1'b1;
        end else if (stop_cond) begin
            state_q <= ST_IDLE;
            sda_oe_n <= 1'b1;
        end else begin
            unique case (state_q)
                ST_IDLE: ;
                ST_ADDR, ST_PTR, ST_WDATA: begin
                    if (scl_rise) begin
                        sh_q <= {sh_q[6:0], sda_s};
                        cnt_q <= cnt_q + 4'd1;
                    end else if (scl_fall && cnt_q == 4'd8) begin
                        cnt_q <= 4'd0;
                        sda_oe_n <= 1'b0;
                        if (state_q == ST_ADDR) begin
                            nack_q <= sh_q[0];
                            if (sh_q[7:1] == DEV_ADDR) begin
                                state_q <= ST_ADDR_ACK;
                            end else begin
                                state_q <= ST_IDLE;
                                sda_oe_n <= 1'b1;
                            end
                        end else if (state_q == ST_PTR) begin
                            ptr_q <= sh_q;
                            state_q <= ST_PTR_ACK;
                        end else begin
                            wr_stb_q <= 1'b1;
                            wr_ptr_q <= ptr_q;
                            wr_data_q <= sh_q;
                            state_q <= ST_WDATA_ACK;
                        end
                    end
                end
                ST_ADDR_ACK, ST_PTR_ACK, ST_WDATA_ACK: begin
                    if (scl_fall) begin
                        sda_oe_n <= 1'b1;
                        if (state_q == ST_ADDR_ACK && nack_q) begin
                            sh_q <= rd_data;
                            sda_oe_n <= rd_data[7];
                            state_q <= ST_RDATA;
                        end else if (state_q == ST_ADDR_ACK) begin
                            state_q <= ST_PTR;
                        end else begin
                            if (state_q == ST_WDATA_ACK) begin
                                ptr_q <= ptr_q + 8'h01;
                            end
                            state_q <= ST_WDATA;
                        end
                    end
                end
                ST_RDATA: begin
                    if (scl_rise) begin
                        cnt_q <= cnt_q + 4'd1;
                    end else if (scl_fall && cnt_q == 4'd8) begin
                        cnt_q <= 4'd0;
                        sda_oe_n <= 1'b1;
                        ptr_q <= ptr_q + 8'h01;
                        state_q <= ST_RDATA_ACK;
                    end else if (scl_fall) begin
                        sh_q <= {sh_q[6:0], 1'b0};
                        sda_oe_n <= sh_q[6];
                    end
                end
                ST_RDATA_ACK: begin
                    if (scl_rise) begin
                        nack_q <= sda_s;
                    end else if (scl_fall && nack_q) begin
                        state_q <= ST_IDLE;
                    end else if (scl_fall) begin
                        sh_q <= rd_data;
                        sda_oe_n <= rd_data[7];
                        state_q <= ST_RDATA;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// file: core/rtc_ctrl_pkg.sv
package rtc_ctrl_pkg;

    // ************************************************************
    // Register offsets and reset values
    // ************************************************************
    localparam logic [7:0] OFS_SECONDS = 8'h00;
    localparam logic [7:0] OFS_MINUTES = 8'h01;
    localparam logic [7:0] OFS_HOURS = 8'h02;
    localparam logic [7:0] OFS_DAY = 8'h03;
    localparam logic [7:0] OFS_DATE = 8'h04;
    localparam logic [7:0] OFS_MONTH = 8'h05;
    localparam logic [7:0] OFS_YEARS = 8'h06;
    localparam logic [7:0] OFS_TRIM = 8'h07;
    localparam logic [7:0] OFS_CHG_SW = 8'h08;
    localparam logic [7:0] OFS_CHG_CFG = 8'h09;
    localparam logic [7:0] OFS_KEY_ONE = 8'h20;
    localparam logic [7:0] OFS_KEY_TWO = 8'h21;
    localparam logic [7:0] OFS_PROT = 8'h22;
    localparam logic [7:0] RST_TRIM = 8'h80;
    localparam logic [7:0] RST_CHG_SW = 8'h90;
    localparam logic [7:0] RST_CHG_CFG = 8'hAA;
    localparam logic [7:0] RST_PROT = 8'h00;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_ONE = 8'h01;

    // ************************************************************
    // Field positions and codes
    // ************************************************************
    localparam int TRIM_OUT_BIT = 7;
    localparam int TRIM_TEST_BIT = 6;
    localparam int TRIM_SIGN_BIT = 5;
    localparam int CHG_PATH_BIT = 5;
    localparam int CHG_BYPASS_BIT = 6;
    localparam int PROT_RATE_BIT = 0;
    localparam int CENT_EN_BIT = 7;
    localparam int CENT_BIT = 6;
    localparam logic [3:0] CHG_CODE_ON = 4'h5;
    localparam logic [7:0] KEY_ONE_VAL = 8'h5E;
    localparam logic [7:0] KEY_TWO_VAL = 8'hC7;
    localparam logic [7:0] KEY_READ_VAL = 8'h00;
    localparam logic [7:0] SEC_MASK = 8'h7F;
    localparam logic [7:0] DAY_MASK = 8'h07;
    localparam logic [7:0] DATE_MASK = 8'h3F;
    localparam logic [7:0] MONTH_MASK = 8'h1F;
    localparam logic [7:0] MAX_SEC = 8'h59;
    localparam logic [7:0] MAX_HOUR = 8'h23;
    localparam logic [7:0] MAX_DAY = 8'h07;
    localparam logic [7:0] MAX_MONTH = 8'h12;
    localparam logic [7:0] MAX_YEAR = 8'h99;

    // ************************************************************
    // Timebase
    // ************************************************************
    localparam int OSC_HZ = 32768;
    localparam int SEC_PER_MIN = 60;
    localparam int SLOW_PARTS = 491520;
    localparam int FAST_PARTS = 245760;
    localparam int SLOW_STEP = OSC_HZ * SEC_PER_MIN / SLOW_PARTS;
    localparam int FAST_STEP = OSC_HZ * SEC_PER_MIN / FAST_PARTS;
    localparam int TEST_DIV_BIT = 5;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000, ST_ADDR = 4'b0001, ST_ADDR_ACK = 4'b0010,
        ST_PTR = 4'b0011, ST_PTR_ACK = 4'b0100, ST_WDATA = 4'b0101,
        ST_WDATA_ACK = 4'b0110, ST_RDATA = 4'b0111, ST_RDATA_ACK = 4'b1000
    } bus_state_t;

    typedef enum logic [1:0] {
        LOCKED = 2'b00, KEY_ONE_SEEN = 2'b01, UNLOCKED = 2'b10
    } unlock_t;

    function automatic logic [7:0] bcd_inc(input logic [7:0] v, input logic [7:0] lo,
                                           input logic [7:0] hi);
        if (v == hi) begin
            return lo;
        end else if (v[3:0] == 4'h9) begin
            return {v[7:4] + 4'h1, 4'h0};
        end
        return v + 8'h01;
    endfunction

    function automatic logic is_leap(input logic [7:0] y);
        if (y[4]) begin
            return (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
        end
        return (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
    endfunction

    function automatic logic [7:0] month_last(input logic [7:0] m, input logic [7:0] y);
        case (m)
            8'h02: return is_leap(y) ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
            default: return 8'h31;
        endcase
    endfunction

endpackage

// file: core/rtc_sync.sv
`timescale 1ns/1ns
`default_nettype none
module rtc_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    if (W < 1) begin : g_bad_width
        $error("synchroniser width must be at least one");
    end

    // First stage feeds only the second stage
    always_ff @(posedge clk) begin
        meta_q <= d;
        q <= meta_q;
    end
endmodule
`default_nettype wire

// file: core/rtc_timebase.sv
`timescale 1ns/1ns
`default_nettype none
module rtc_timebase
    import rtc_ctrl_pkg::*;
(
    input wire logic osc_clk,
    input wire logic nrst,
    input wire logic [6:0] trim_cfg,
    output logic wave_q,
    output logic sec_toggle_q
);
    logic [7:0] sync_out;
    logic [6:0] cfg_prev_q;
    logic [6:0] cfg_q;
    logic rst_n;
    logic [16:0] div_q;
    logic [16:0] period;
    logic [5:0] sec_in_min_q;
    logic [5:0] raw_q;

    rtc_sync #(.W(8)) u_cfg_sync (
        .clk(osc_clk),
        .d({nrst, trim_cfg}),
        .q(sync_out)
    );
    assign rst_n = sync_out[7];

    // Trim word is quasi-static; only a value seen twice is taken
    always_ff @(posedge osc_clk) begin
        cfg_prev_q <= sync_out[6:0];
        if (!rst_n) begin
            cfg_q <= 7'h00;
        end else if (cfg_prev_q == sync_out[6:0]) begin
            cfg_q <= cfg_prev_q;
        end
    end

    // Trim is applied to the first second of each minute only
    always_comb begin
        period = 17'(OSC_HZ);
        if (sec_in_min_q == 6'd0) begin
            if (cfg_q[TRIM_SIGN_BIT]) begin
                period = 17'(OSC_HZ) - 17'(FAST_STEP) * 17'(cfg_q[4:0]);
            end else begin
                period = 17'(OSC_HZ) + 17'(SLOW_STEP) * 17'(cfg_q[4:0]);
            end
        end
    end

    always_ff @(posedge osc_clk) begin
        if (!rst_n) begin
            div_q <= 17'd0;
            sec_in_min_q <= 6'd0;
            sec_toggle_q <= 1'b0;
        end else if (div_q >= period - 17'd1) begin
            div_q <= 17'd0;
            sec_toggle_q <= ~sec_toggle_q;
            sec_in_min_q <= (sec_in_min_q == 6'(SEC_PER_MIN - 1)) ? 6'd0 : sec_in_min_q + 6'd1;
        end else begin
            div_q <= div_q + 17'd1;
        end
    end

    // 512 Hz comes from the free divider, so it never sees the trim
    always_ff @(posedge osc_clk) begin
        if (!rst_n) begin
            raw_q <= 6'd0;
            wave_q <= 1'b0;
        end else begin
            raw_q <= raw_q + 6'd1;
            wave_q <= cfg_q[6] ? (div_q < 17'(OSC_HZ / 2)) : raw_q[TEST_DIV_BIT];
        end
    end
endmodule
`default_nettype wire

// file: dv/rtc_ctrl_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module rtc_ctrl_assertions (
    input wire logic clk,
    input wire logic nrst,
    input wire logic osc_clk,
    input wire logic scl,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic backup_supply,
    input wire logic irq,
    input wire logic charger_path_closed,
    input wire logic charger_diode_bypass,
    input wire logic charger_active
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    sequence s_bk;
        backup_supply [*4];
    endsequence
    property p_rst;
        $rose(nrst) |-> irq && !charger_path_closed && !charger_diode_bypass && !charger_active;
    endproperty
    a_rst: assert property (p_rst) else $error("bad reset outputs");
    property p_act;
        charger_active |-> charger_path_closed;
    endproperty
    a_act: assert property (p_act) else $error("charger on with path open");
    property p_act_bus;
        $changed(charger_active) |-> !scl;
    endproperty
    a_act_bus: assert property (p_act_bus) else $error("charger moved off a write");
    property p_sw_bus;
        $changed(charger_diode_bypass) || $changed(charger_path_closed) |-> !scl;
    endproperty
    a_sw_bus: assert property (p_sw_bus) else $error("switch moved off a write");
    property p_bk_quiet;
        s_bk |-> sda_oe_n;
    endproperty
    a_bk_quiet: assert property (p_bk_quiet) else $error("bus answered on backup");
    property p_bk_keep;
        s_bk |=> $stable({charger_path_closed, charger_diode_bypass, charger_active});
    endproperty
    a_bk_keep: assert property (p_bk_keep) else $error("register written on backup");
    property p_od;
        !sda_out;
    endproperty
    a_od: assert property (p_od) else $error("data pin driven high");
    property p_oe;
        $changed(sda_oe_n) |-> !scl;
    endproperty
    a_oe: assert property (p_oe) else $error("data moved while bus clock high");
endmodule
bind rtc_ctrl rtc_ctrl_assertions u_chk (
    .clk(clk), .nrst(nrst), .osc_clk(osc_clk), .scl(scl), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .backup_supply(backup_supply), .irq(irq),
    .charger_path_closed(charger_path_closed), .charger_diode_bypass(charger_diode_bypass),
    .charger_active(charger_active)
);
`default_nettype wire

// file: dv/i2c_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module i2c_host_model #(
    parameter logic [6:0] DEV_ADDR = 7'h50
) (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_rel
);
    // ****
    // Bus phases
    // ****
    initial begin
        scl = 1'h1;
        sda_rel = 1'h1;
    end
    task automatic waitc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Data moves a few cycles after the clock falls so no false start or stop is seen
    task automatic bit_io(input logic b, output logic r);
        waitc(4);
        sda_rel = b;
        waitc(16);
        scl = 1'h1;
        waitc(16);
        r = sda;
        scl = 1'h0;
    endtask
    task automatic start();
        waitc(4);
        sda_rel = 1'h1;
        waitc(16);
        scl = 1'h1;
        waitc(16);
        sda_rel = 1'h0;
        waitc(16);
        scl = 1'h0;
    endtask
    task automatic stop();
        waitc(4);
        sda_rel = 1'h0;
        waitc(16);
        scl = 1'h1;
        waitc(16);
        sda_rel = 1'h1;
        waitc(16);
    endtask
    task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx, output logic ack_n);
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(1'h1, ack_n);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic nak);
        logic [7:0] rx;
        logic n1, n2, n3;
        start();
        byte_io({DEV_ADDR, 1'h0}, rx, n1);
        byte_io(a, rx, n2);
        byte_io(d, rx, n3);
        stop();
        nak = n1 | n2 | n3;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        logic [7:0] rx;
        logic n;
        start();
        byte_io({DEV_ADDR, 1'h0}, rx, n);
        byte_io(a, rx, n);
        start();
        byte_io({DEV_ADDR, 1'h1}, rx, n);
        byte_io(8'hFF, d, n);
        stop();
    endtask
endmodule
`default_nettype wire

// file: dv/tb_rtc_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module tb_rtc_ctrl;
    import rtc_ctrl_pkg::*;
    logic clk = 1'h0;
    logic osc_clk = 1'h0;
    logic nrst = 1'h0;
    logic backup_supply = 1'h0;
    logic scl, sda_rel, sda_out, sda_oe_n, irq, path_c, bypass, active, nak;
    int failures = 0;
    int tests_run = 0;
    wire logic sda_line;
    wire logic [7:0] pins;
    assign sda_line = sda_rel & (sda_oe_n | sda_out);
    assign pins = {4'h0, irq, path_c, bypass, active};
    always #4 clk = ~clk;
    always begin
        #7 osc_clk = ~osc_clk;
        #8 osc_clk = ~osc_clk;
    end
    rtc_ctrl u_dut (.clk(clk), .nrst(nrst), .osc_clk(osc_clk), .scl(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .backup_supply(backup_supply), .irq(irq),
        .charger_path_closed(path_c), .charger_diode_bypass(bypass), .charger_active(active));
    i2c_host_model u_host (.clk(clk), .sda(sda_line), .scl(scl), .sda_rel(sda_rel));
    // ****
    // Checks and bus helpers
    // ****
    task automatic close_out();
        if (failures == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        u_host.rd(a, d);
        chk(d, exp);
    endtask
    task automatic w(input logic [7:0] a, input logic [7:0] d);
        u_host.wr(a, d, nak);
        chk({7'h0, nak}, 8'h00);
    endtask
    task automatic try_keys(input logic [7:0] a1, v1, a2, v2, d, exp);
        w(a1, v1);
        w(a2, v2);
        w(OFS_PROT, d);
        rchk(OFS_PROT, exp);
    endtask
    // ****
    // Scenarios
    // ****
    task automatic t_reset();
        chk(pins, 8'h08);
        rchk(OFS_TRIM, 8'h80);
        rchk(OFS_CHG_SW, 8'h90);
        rchk(OFS_CHG_CFG, 8'hAA);
        rchk(OFS_PROT, 8'h00);
        rchk(OFS_KEY_ONE, 8'h00);
        rchk(OFS_KEY_TWO, 8'h00);
        rchk(8'h30, 8'h00);
    endtask
    task automatic t_static();
        w(OFS_TRIM, 8'h00);
        chk(pins, 8'h00);
        w(OFS_TRIM, 8'h80);
        chk(pins, 8'h08);
    endtask
    // Reserved bits are always written as zero here
    task automatic t_charger();
        w(OFS_CHG_SW, 8'h20);
        for (int c = 0; c < 16; c++) begin
            w(OFS_CHG_CFG, {4'h4, c[3:0]});
            chk(pins, (c == 5) ? 8'h0F : 8'h0E);
        end
        w(OFS_CHG_CFG, 8'h45);
        w(OFS_CHG_SW, 8'h00);
        chk(pins, 8'h0A);
    endtask
    task automatic t_backup();
        backup_supply = 1'h1;
        u_host.wr(OFS_TRIM, 8'h00, nak);
        chk({6'h0, nak, irq}, 8'h03);
        backup_supply = 1'h0;
        rchk(OFS_TRIM, 8'h80);
    endtask
    task automatic t_wave();
        time t;
        w(OFS_TRIM, 8'h5F);
        @(posedge irq);
        t = $time;
        @(posedge irq);
        chk({7'h0, ($time - t) >= 944 && ($time - t) <= 976}, 8'h01);
    endtask
    task automatic t_keys();
        int n;
        logic lv;
        try_keys(OFS_KEY_ONE, 8'h5E, OFS_KEY_TWO, 8'hC6, 8'h01, 8'h00);
        w(OFS_KEY_ONE, 8'h5E);
        w(OFS_KEY_TWO, 8'hC7);
        w(OFS_PROT, 8'h01);
        rchk(OFS_PROT, 8'h01);
        n = 0;
        lv = irq;
        repeat (2000) begin
            @(negedge clk);
            if (irq !== lv) n++;
            lv = irq;
        end
        chk({7'h0, n <= 1}, 8'h01);
        rchk(OFS_KEY_ONE, 8'h00);
        try_keys(OFS_KEY_ONE, 8'h5E, OFS_TRIM, 8'h5F, 8'h00, 8'h01);
        try_keys(OFS_KEY_TWO, 8'hC7, OFS_KEY_ONE, 8'h5E, 8'h00, 8'h01);
        try_keys(OFS_KEY_ONE, 8'h5D, OFS_KEY_TWO, 8'hC7, 8'h00, 8'h01);
        try_keys(OFS_KEY_ONE, 8'h5E, OFS_KEY_TWO, 8'hC7, 8'h00, 8'h00);
        w(OFS_PROT, 8'h01);
        rchk(OFS_PROT, 8'h00);
    endtask
    initial begin
        #760000;
        failures++;
        close_out();
    end
    initial begin
        repeat (16) @(posedge clk);
        #1;
        nrst = 1'h1;
        t_reset();
        t_static();
        t_charger();
        t_backup();
        t_wave();
        t_keys();
        close_out();
    end
endmodule
`default_nettype wire
